// File: hdl/pecnt_top.sv
// two performance event counters with control registers and move access
// Overview of operation
// - two independent 32-bit read/write counters, each with its own control register
// - each counter adds one when its selected event occurs, independently
// - overflow interrupt when counter bit 31 is one and its enable is set
// - counter keeps incrementing after bit 31 set, interrupt or not
// - write decodes register field 11001 and low bits: ctl0, cnt0, ctl1, cnt1
// - read uses the same decoding to return ctl0, cnt0, ctl1 or cnt1
// - control holds event select 8:5, interrupt enable 4, mode enables 3:0
// - software writes zero to unused control bits; they read back as zero
// - counter 0 event selects 1..15 choose its event sources 1..15 in order; select 0 counts cycles
// - counter 1 event selects 1..15 choose its event sources 1..15 in order; select 0 counts cycles
// - user/supervisor/kernel enables need privilege 2/1/0; exception enable needs exception level
// - any combination of mode enables is accepted; each set mode counts
// - error level set suppresses all counting on both counters
// - counter takes preloaded value; counting starts once a mode enable is set
// - overflow interrupt is shared with timer compare match; software sorts sources
// - event select zero counts every processor clock cycle
`timescale 1ns/1ps
`include "pecnt_cfg.svh"
module pecnt_top (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic MOVE_TO_I,
    input wire logic MOVE_FROM_I,
    input wire logic [15:0] INSTR_I,
    input wire pecnt_pkg::pecnt_word_t WDATA_I,
    output pecnt_pkg::pecnt_word_t RDATA_O,
    output logic RVALID_O,
    input wire logic [15:0] EVENTS0_I,
    input wire logic [15:0] EVENTS1_I,
    input wire logic [1:0] PRIVILEGE_MODE_FIELD_I,
    input wire logic EXCEPTION_LEVEL_I,
    input wire logic ERROR_LEVEL_I,
    input wire logic TIMER_MATCH_I,
    output logic PERF_OVERFLOW_IRQ_O
);
    import pecnt_pkg::*;

    // ------------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------------
    function automatic logic is_perf_reg(input logic [15:0] instr);
        is_perf_reg = (instr[`PECNT_REG_FIELD_HI:`PECNT_REG_FIELD_LO] == `PECNT_REG_NUMBER);
    endfunction : is_perf_reg

    function automatic pecnt_sel_e reg_sel(input logic [15:0] instr);
        reg_sel = pecnt_sel_e'(instr[`PECNT_SEL_HI:`PECNT_SEL_LO]);
    endfunction : reg_sel

    function automatic pecnt_word_t ctl_word(input pecnt_ctl_t ctl);
        ctl_word = {23'h000000, ctl};
    endfunction : ctl_word

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    pecnt_state_s q_r;
    pecnt_state_s q_nxt;

    logic wr_hit;
    logic rd_hit;
    pecnt_sel_e wr_sel;
    pecnt_sel_e rd_sel;
    logic ok0;
    logic ok1;
    logic hit0;
    logic hit1;
    logic inc0;
    logic inc1;
    logic wr_cnt0;
    logic wr_cnt1;

    // ------------------------------------------------------------------------
    // mode qualification and event selection
    // ------------------------------------------------------------------------
    pecnt_mode_qual u_qual0 (
        .mode_en_i(q_r.ctl0[`PECNT_EN_USER_BIT:`PECNT_EN_EXC_BIT]),
        .priv_mode_field_i(PRIVILEGE_MODE_FIELD_I),
        .exception_level_i(EXCEPTION_LEVEL_I),
        .error_level_i(ERROR_LEVEL_I),
        .count_ok_o(ok0)
    );

    pecnt_mode_qual u_qual1 (
        .mode_en_i(q_r.ctl1[`PECNT_EN_USER_BIT:`PECNT_EN_EXC_BIT]),
        .priv_mode_field_i(PRIVILEGE_MODE_FIELD_I),
        .exception_level_i(EXCEPTION_LEVEL_I),
        .error_level_i(ERROR_LEVEL_I),
        .count_ok_o(ok1)
    );

    pecnt_event_mux u_mux0 (
        .evsel_i(q_r.ctl0[`PECNT_EVSEL_HI:`PECNT_EVSEL_LO]),
        .events_i(EVENTS0_I),
        .hit_o(hit0)
    );

    pecnt_event_mux u_mux1 (
        .evsel_i(q_r.ctl1[`PECNT_EVSEL_HI:`PECNT_EVSEL_LO]),
        .events_i(EVENTS1_I),
        .hit_o(hit1)
    );

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        q_nxt = q_r;
        wr_hit = MOVE_TO_I && is_perf_reg(INSTR_I);
        rd_hit = MOVE_FROM_I && is_perf_reg(INSTR_I);
        wr_sel = reg_sel(INSTR_I);
        rd_sel = reg_sel(INSTR_I);
        wr_cnt0 = wr_hit && wr_sel == SEL_CNT0;
        wr_cnt1 = wr_hit && wr_sel == SEL_CNT1;
        inc0 = ok0 && hit0 && !ERROR_LEVEL_I;
        inc1 = ok1 && hit1 && !ERROR_LEVEL_I;

        // counters wrap silently past all ones and keep going
        if (inc0) begin
            q_nxt.cnt0 = q_r.cnt0 + 32'h0000_0001;
        end
        if (inc1) begin
            q_nxt.cnt1 = q_r.cnt1 + 32'h0000_0001;
        end

        if (wr_hit) begin
            case (wr_sel)
                SEL_CTL0: begin
                    q_nxt.ctl0 = WDATA_I[`PECNT_CTL_WIDTH-1:0];
                end
                SEL_CNT0: begin
                    q_nxt.cnt0 = WDATA_I;
                end
                SEL_CTL1: begin
                    q_nxt.ctl1 = WDATA_I[`PECNT_CTL_WIDTH-1:0];
                end
                SEL_CNT1: begin
                    q_nxt.cnt1 = WDATA_I;
                end
                default: begin
                    q_nxt.cnt0 = q_nxt.cnt0;
                end
            endcase
        end

        // read port answers one cycle later
        q_nxt.rvalid = rd_hit;
        if (rd_hit) begin
            case (rd_sel)
                SEL_CTL0: begin
                    q_nxt.rdata = ctl_word(q_r.ctl0);
                end
                SEL_CNT0: begin
                    q_nxt.rdata = q_r.cnt0;
                end
                SEL_CTL1: begin
                    q_nxt.rdata = ctl_word(q_r.ctl1);
                end
                SEL_CNT1: begin
                    q_nxt.rdata = q_r.cnt1;
                end
                default: begin
                    q_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end

        // shared interrupt line; tracks bit 31 of the next counter values
        q_nxt.irq = (q_nxt.cnt0[31] && q_nxt.ctl0[`PECNT_IE_BIT])
                  || (q_nxt.cnt1[31] && q_nxt.ctl1[`PECNT_IE_BIT])
                  || TIMER_MATCH_I;
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            q_r.cnt0 <= `PECNT_CNT_RESET;
            q_r.cnt1 <= `PECNT_CNT_RESET;
            q_r.ctl0 <= `PECNT_CTL_RESET;
            q_r.ctl1 <= `PECNT_CTL_RESET;
            q_r.rdata <= 32'h0000_0000;
            q_r.rvalid <= 1'b0;
            q_r.irq <= 1'b0;
        end else if (CE_I) begin
            q_r <= q_nxt;
        end
    end

    assign RDATA_O = q_r.rdata;
    assign RVALID_O = q_r.rvalid;
    assign PERF_OVERFLOW_IRQ_O = q_r.irq;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    sequence s_read_cnt0;
        CE_I && MOVE_FROM_I && is_perf_reg(INSTR_I) && reg_sel(INSTR_I) == SEL_CNT0;
    endsequence

    sequence s_answer;
        RVALID_O;
    endsequence

    property p_cnt0_inc;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && !wr_cnt0 && ok0 && hit0 && !ERROR_LEVEL_I)
        |=> (q_r.cnt0 == $past(q_r.cnt0) + 32'h0000_0001);
    endproperty
    a_cnt0_inc: assert property (p_cnt0_inc) else $error("counter 0 missed an increment");

    property p_cnt1_idle;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && !wr_cnt1 && !(ok1 && hit1)) |=> $stable(q_r.cnt1);
    endproperty
    a_cnt1_idle: assert property (p_cnt1_idle) else $error("counter 1 moved without an event");

    property p_irq_set;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && q_nxt.cnt0[31] && q_nxt.ctl0[`PECNT_IE_BIT]) |=> PERF_OVERFLOW_IRQ_O;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("overflow interrupt not raised");

    property p_irq_quiet;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && !TIMER_MATCH_I && !q_nxt.ctl0[`PECNT_IE_BIT] && !q_nxt.ctl1[`PECNT_IE_BIT])
        |=> !PERF_OVERFLOW_IRQ_O;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt raised with enables clear");

    property p_wrap;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && inc0 && !wr_cnt0 && q_r.cnt0 == 32'hffff_ffff) |=> (q_r.cnt0 == 32'h0000_0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter 0 stopped after overflow");

    property p_write_wins;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && wr_cnt1) |=> (q_r.cnt1 == $past(WDATA_I));
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("counter write lost to an event");

    property p_ctl_write;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && wr_hit && wr_sel == SEL_CTL0) |=> (q_r.ctl0 == $past(WDATA_I[8:0]));
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("control 0 write not stored");

    property p_read_cnt0;
        @(posedge CLOCK_I) disable iff (RST_I)
        s_read_cnt0 |=> s_answer ##0 (RDATA_O == $past(q_r.cnt0));
    endproperty
    a_read_cnt0: assert property (p_read_cnt0) else $error("counter 0 read returned wrong data");

    property p_ctl_zero;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && rd_hit && (rd_sel == SEL_CTL0 || rd_sel == SEL_CTL1)) |=> (RDATA_O[31:9] == 23'h000000);
    endproperty
    a_ctl_zero: assert property (p_ctl_zero) else $error("unused control bits read non-zero");

    property p_err_freeze;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && ERROR_LEVEL_I && !wr_hit) |=> ($stable(q_r.cnt0) && $stable(q_r.cnt1));
    endproperty
    a_err_freeze: assert property (p_err_freeze) else $error("counting while error level set");

    property p_no_enable;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && q_r.ctl0[3:0] == 4'h0 && !wr_cnt0) |=> $stable(q_r.cnt0);
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("counter 0 counts with no mode enabled");

    property p_cycles;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && q_r.ctl1[8:5] == 4'h0 && q_r.ctl1[`PECNT_EN_KERNEL_BIT]
            && PRIVILEGE_MODE_FIELD_I == 2'h0 && !EXCEPTION_LEVEL_I && !ERROR_LEVEL_I && !wr_cnt1)
        |=> (q_r.cnt1 == $past(q_r.cnt1) + 32'h0000_0001);
    endproperty
    a_cycles: assert property (p_cycles) else $error("cycle event did not count");

    property p_user_mode;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CE_I && q_r.ctl0[3:0] == 4'h8 && PRIVILEGE_MODE_FIELD_I != 2'h2 && !wr_cnt0) |=> $stable(q_r.cnt0);
    endproperty
    a_user_mode: assert property (p_user_mode) else $error("user enable counted outside user mode");

    property p_freeze;
        @(posedge CLOCK_I) disable iff (RST_I)
        !CE_I |=> ($stable(q_r.cnt0) && $stable(RVALID_O) && $stable(PERF_OVERFLOW_IRQ_O));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

endmodule : pecnt_top

// File: hdl/pecnt_cfg.svh
// register selection codes, control field positions, reset values
`ifndef PECNT_CFG_SVH
`define PECNT_CFG_SVH

// ----------------------------------------------------------------------------
// instruction decode
// ----------------------------------------------------------------------------
`define PECNT_REG_FIELD_HI 15
`define PECNT_REG_FIELD_LO 11
`define PECNT_REG_NUMBER 5'h19
`define PECNT_SEL_HI 1
`define PECNT_SEL_LO 0

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define PECNT_CTL_WIDTH 9
`define PECNT_EVSEL_HI 8
`define PECNT_EVSEL_LO 5
`define PECNT_IE_BIT 4
`define PECNT_EN_USER_BIT 3
`define PECNT_EN_SUPER_BIT 2
`define PECNT_EN_KERNEL_BIT 1
`define PECNT_EN_EXC_BIT 0

// ----------------------------------------------------------------------------
// privilege field values and reset values
// ----------------------------------------------------------------------------
`define PECNT_PRIV_USER 2'h2
`define PECNT_PRIV_SUPER 2'h1
`define PECNT_PRIV_KERNEL 2'h0
`define PECNT_EVSEL_CYCLES 4'h0
`define PECNT_CTL_RESET 9'h000
`define PECNT_CNT_RESET 32'h0000_0000

`endif

// File: hdl/pecnt_pkg.sv
// types shared by the event counter design files
package pecnt_pkg;

    typedef logic [31:0] pecnt_word_t;
    typedef logic [8:0] pecnt_ctl_t;

    typedef enum logic [1:0] {
        SEL_CTL0,
        SEL_CNT0,
        SEL_CTL1,
        SEL_CNT1
    } pecnt_sel_e;

    typedef struct packed {
        pecnt_word_t cnt0;
        pecnt_word_t cnt1;
        pecnt_ctl_t ctl0;
        pecnt_ctl_t ctl1;
        pecnt_word_t rdata;
        logic rvalid;
        logic irq;
    } pecnt_state_s;

endpackage : pecnt_pkg

// File: hdl/pecnt_mode_qual.sv
// privilege and exception level qualifier for one counter
`timescale 1ns/1ps
`include "pecnt_cfg.svh"
module pecnt_mode_qual (
    input wire logic [3:0] mode_en_i,
    input wire logic [1:0] priv_mode_field_i,
    input wire logic exception_level_i,
    input wire logic error_level_i,
    output logic count_ok_o
);
    logic base_lvl;

    always_comb begin
        base_lvl = !exception_level_i && !error_level_i;
        count_ok_o = 1'b0;
        if (mode_en_i[`PECNT_EN_USER_BIT] && base_lvl && priv_mode_field_i == `PECNT_PRIV_USER) begin
            count_ok_o = 1'b1;
        end
        if (mode_en_i[`PECNT_EN_SUPER_BIT] && base_lvl && priv_mode_field_i == `PECNT_PRIV_SUPER) begin
            count_ok_o = 1'b1;
        end
        if (mode_en_i[`PECNT_EN_KERNEL_BIT] && base_lvl && priv_mode_field_i == `PECNT_PRIV_KERNEL) begin
            count_ok_o = 1'b1;
        end
        if (mode_en_i[`PECNT_EN_EXC_BIT] && exception_level_i && !error_level_i) begin
            count_ok_o = 1'b1;
        end
        // error level blocks everything
        if (error_level_i) begin
            count_ok_o = 1'b0;
        end
    end
endmodule : pecnt_mode_qual

// File: hdl/pecnt_event_mux.sv
// selects one of event pulses 1..15 (pulse 0 is never chosen); select zero counts every cycle
`timescale 1ns/1ps
`include "pecnt_cfg.svh"
module pecnt_event_mux (
    input wire logic [3:0] evsel_i,
    input wire logic [15:0] events_i,
    output logic hit_o
);
    always_comb begin
        if (evsel_i == `PECNT_EVSEL_CYCLES) begin
            hit_o = 1'b1;
        end else begin
            hit_o = events_i[evsel_i];
        end
    end
endmodule : pecnt_event_mux

// File: test/pecnt_core_model.sv
// pipeline event source model feeding both counters
`timescale 1ns/1ps
module pecnt_core_model (
    input wire logic active_i,
    input wire logic target_i,
    input wire logic [3:0] evsel_i,
    output logic [15:0] events0_o,
    output logic [15:0] events1_o
);
    logic [15:0] hit;
    logic [15:0] rest;
    // ------------------------------------------------------------------------
    // event pulses
    // ------------------------------------------------------------------------
    // only the chosen source fires on the target counter; all others fire on the other one
    assign hit = active_i ? (16'h0001 << evsel_i) : 16'h0000;
    assign rest = active_i ? ~hit : 16'h0000;
    assign events0_o = target_i ? rest : hit;
    assign events1_o = target_i ? hit : rest;
endmodule : pecnt_core_model

// File: test/perf_event_counters_tb_top.sv
// self-checking bench for the performance event counters
`timescale 1ns/1ps
`include "pecnt_cfg.svh"
`define CHK(got, exp) check_val(got, exp)
module perf_event_counters_tb_top;
    import pecnt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic mv_to = 1'b0;
    logic mv_from = 1'b0;
    logic [15:0] instr = 16'h0000;
    pecnt_word_t wdata = 32'h0000_0000;
    pecnt_word_t rdata;
    logic rvalid;
    logic [15:0] ev0;
    logic [15:0] ev1;
    logic [1:0] priv = 2'h0;
    logic exception_level = 1'b0;
    logic error_level = 1'b0;
    logic tmatch = 1'b0;
    logic irq;
    logic ev_on = 1'b0;
    logic ev_tgt = 1'b0;
    logic [3:0] ev_sel = 4'h0;
    int fails = 0;
    int checks = 0;
    pecnt_word_t v;
    logic [3:0] mask;
    logic ok;
    logic [1:0] row_sel [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    pecnt_word_t row_wr [4] = '{32'hffff_fff0, 32'hdead_beef, 32'hffff_ffe0, 32'h1234_5678};
    pecnt_word_t row_exp [4] = '{32'h0000_01f0, 32'hdead_beef, 32'h0000_01e0, 32'h1234_5678};

    always #20 clk = ~clk;

    pecnt_top uut (.CLOCK_I(clk), .RST_I(rst), .CE_I(ce), .MOVE_TO_I(mv_to), .MOVE_FROM_I(mv_from),
        .INSTR_I(instr), .WDATA_I(wdata), .RDATA_O(rdata), .RVALID_O(rvalid), .EVENTS0_I(ev0),
        .EVENTS1_I(ev1), .PRIVILEGE_MODE_FIELD_I(priv), .EXCEPTION_LEVEL_I(exception_level), .ERROR_LEVEL_I(error_level),
        .TIMER_MATCH_I(tmatch), .PERF_OVERFLOW_IRQ_O(irq));

    pecnt_core_model u_core (.active_i(ev_on), .target_i(ev_tgt), .evsel_i(ev_sel), .events0_o(ev0),
        .events1_o(ev1));

    // ------------------------------------------------------------------------
    // helpers: called at a falling edge, except stop_test from the timeout at a rising edge
    // ------------------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    function automatic logic [15:0] code(input logic [1:0] s);
        return {`PECNT_REG_NUMBER, 9'h000, s};
    endfunction : code

    task automatic wr(input logic [1:0] s, input pecnt_word_t d);
        mv_to = 1'b1;
        instr = code(s);
        wdata = d;
        @(negedge clk);
        mv_to = 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] s, output pecnt_word_t d);
        mv_from = 1'b1;
        instr = code(s);
        @(negedge clk);
        mv_from = 1'b0;
        `CHK(rvalid, 32'h1);
        d = rdata;
    endtask : rd

    // clears a counter, lets n cycles pass, then reads it back
    task automatic cnt_after(input logic c, input int n, input pecnt_word_t exp);
        pecnt_word_t r;
        wr({c, 1'b1}, 32'h0000_0000);
        repeat (n) @(negedge clk);
        rd({c, 1'b1}, r);
        `CHK(r, exp);
    endtask : cnt_after

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        `CHK(rdata, 32'h0);
        `CHK({30'h0, rvalid, irq}, 32'h0);
        // write every register, then read all back: unused control bits read zero
        for (int i = 0; i < 4; i++) begin
            wr(row_sel[i], row_wr[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rd(row_sel[i], v);
            `CHK(v, row_exp[i]);
        end
        `CHK(irq, 1'b1);
        wr(2'h0, 32'h0);
        wr(2'h2, 32'h0);
        // unmatched register field: no answer, no write
        mv_from = 1'b1;
        instr = 16'hc001;
        @(negedge clk);
        mv_from = 1'b0;
        `CHK(rvalid, 1'b0);
        mv_to = 1'b1;
        instr = 16'hc003;
        wdata = 32'hffff_ffff;
        @(negedge clk);
        mv_to = 1'b0;
        rd(2'h3, v);
        `CHK(v, 32'h1234_5678);
        // mode qualification over privilege, exception and error levels
        for (int c = 0; c < 2; c++) begin
            for (int p = 0; p < 3; p++) begin
                for (int e = 0; e < 4; e++) begin
                    for (int m = 0; m < 5; m++) begin
                        mask = (m == 4) ? 4'hf : (4'h1 << m);
                        ok = (mask[3] && p == 2 && e == 0) || (mask[2] && p == 1 && e == 0)
                            || (mask[1] && p == 0 && e == 0) || (mask[0] && e == 1);
                        priv = 2'(p);
                        exception_level = e[0];
                        error_level = e[1];
                        wr({c[0], 1'b0}, {28'h0, mask});
                        cnt_after(c[0], 4, ok ? 32'h4 : 32'h0);
                    end
                end
            end
            wr({c[0], 1'b0}, 32'h0);
        end
        // event selection on both counters in kernel mode
        priv = 2'h0;
        exception_level = 1'b0;
        error_level = 1'b0;
        for (int c = 0; c < 2; c++) begin
            for (int s = 1; s < 16; s++) begin
                wr({c[0], 1'b0}, {23'h0, 4'(s), 5'h02});
                wr({~c[0], 1'b0}, {23'h0, 4'(s), 5'h02});
                ev_tgt = c[0];
                ev_sel = 4'(s);
                wr({~c[0], 1'b1}, 32'h0);
                wr({c[0], 1'b1}, 32'h0);
                ev_on = 1'b1;
                repeat (3) @(negedge clk);
                ev_on = 1'b0;
                repeat (2) @(negedge clk);
                rd({c[0], 1'b1}, v);
                `CHK(v, 32'h3);
                rd({~c[0], 1'b1}, v);
                `CHK(v, 32'h0);
            end
            wr({c[0], 1'b0}, 32'h0);
        end
        // clock enable low freezes counting
        wr(2'h0, 32'h0000_0002);
        wr(2'h1, 32'h0);
        repeat (2) @(negedge clk);
        ce = 1'b0;
        repeat (3) @(negedge clk);
        ce = 1'b1;
        @(negedge clk);
        rd(2'h1, v);
        `CHK(v, 32'h3);
        // overflow interrupt rises with bit 31 and counting goes on
        wr(2'h0, 32'h0000_0012);
        wr(2'h1, 32'h7fff_fffe);
        `CHK(irq, 1'b0);
        @(negedge clk);
        `CHK(irq, 1'b0);
        @(negedge clk);
        `CHK(irq, 1'b1);
        repeat (2) @(negedge clk);
        rd(2'h1, v);
        `CHK(v, 32'h8000_0002);
        wr(2'h0, 32'h0000_0002);
        @(negedge clk);
        `CHK(irq, 1'b0);
        tmatch = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b1);
        tmatch = 1'b0;
        wr(2'h0, 32'h0);
        wr(2'h2, 32'h0000_0010);
        wr(2'h3, 32'h8000_0000);
        @(negedge clk);
        `CHK(irq, 1'b1);
        wr(2'h2, 32'h0);
        @(negedge clk);
        `CHK(irq, 1'b0);
        // second reset in mid-run
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rd(2'h3, v);
        `CHK(v, 32'h0);
        stop_test();
    end
endmodule : perf_event_counters_tb_top
